// ---- nps_regs.svh ----
/*
  Constants of the nonvolatile memory programming sequencer: fuse and lock
  layout, reset values, page sizes and the self-timed cycle figures.
  Assumes a 125 MHz sequencer clock; included by bare name.
*/
`ifndef NPS_REGS_SVH
`define NPS_REGS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define NPS_CLK_PERIOD_NS   8
`define NPS_T_FIXED_NS      8000000
`define NPS_T_PAGE_NS       4500000
`define NPS_T_ERASE_MAX_NS  9000000
`define NPS_T_LOAD_GAP_NS   150000
`define NPS_T_BUSY_MAX_NS   256000
`define NPS_FIXED_CYC       (`NPS_T_FIXED_NS / `NPS_CLK_PERIOD_NS)
`define NPS_PAGE_CYC        (`NPS_T_PAGE_NS / `NPS_CLK_PERIOD_NS)
`define NPS_ERASE_MAX_CYC   (`NPS_T_ERASE_MAX_NS / `NPS_CLK_PERIOD_NS)
`define NPS_LOAD_GAP_CYC    ((`NPS_T_LOAD_GAP_NS + `NPS_CLK_PERIOD_NS - 1) / `NPS_CLK_PERIOD_NS)
`define NPS_BUSY_MAX_CYC    (`NPS_T_BUSY_MAX_NS / `NPS_CLK_PERIOD_NS)

// ****************************************************************
// Page sizes
// ****************************************************************
`define NPS_CODE_PAGE_BYTES 64
`define NPS_DATA_PAGE_BYTES 32

// ****************************************************************
// Fuse and lock fields, timer width
// ****************************************************************
`define NPS_FUSE_SER_EN_BIT  0
`define NPS_FUSE_X2_BIT      1
`define NPS_FUSE_USR_ROW_BIT 2
`define NPS_FUSE_CLK_SEL_BIT 3
`define NPS_FUSE_RESET       4'h0
`define NPS_LOCK_RESET       3'h7
`define NPS_TMR_W            20

`endif

// ---- nps_pkg.sv ----
/*
  Types of the nonvolatile memory programming sequencer.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package nps_pkg;

  // ****************************************************************
  // Operations and sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_NONE      = 3'h0,
    OP_ERASE     = 3'h1,
    OP_CODE_PAGE = 3'h2,
    OP_DATA_PAGE = 3'h3,
    OP_USER_PAGE = 3'h4,
    OP_LOCK      = 3'h5,
    OP_FUSE      = 3'h6
  } nps_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOAD = 2'h1,
    ST_WAIT = 2'h2,
    ST_PROG = 2'h3
  } nps_state_t;

endpackage : nps_pkg
`default_nettype wire

// ---- nps_buf.sv ----
/*
  Small valid/ready FIFO standing in the page byte path.
  Assumes one clock and an active-low asynchronous reset.
*/
`default_nettype none
module nps_buf #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 2
) (
  input  wire logic             mclk_i,
  input  wire logic             nrst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  empty_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
    $error("nps_buf: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_q != AW'(0) + (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign empty_o     = (cnt_q == '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : nps_buf
`default_nettype wire

// ---- nps_sequencer.sv ----
/*
  Programming sequencer for the on-chip code and data nonvolatile memory:
  parallel strobed port and SPI mode 1 serial download, page loading,
  self-timed erase and write cycles, busy pin and the four fuses.
  Assumes the pins are asynchronous to mclk_i and that the memory array
  takes page bytes over nvm_valid_o/nvm_ready_i.
*/
// Contract
// - Erase, lock and fuse writes run a self-timed 8.0 ms cycle.
// - Parallel page programming starts at least 150 us after last strobe.
// - Busy pin is driven low while internal programming runs.
// - Code page takes one to 64 bytes; extra bytes are dropped.
// - Data page takes one to 32 bytes; extra bytes are dropped.
// - Serial programming works only while the serial enable fuse is enabled.
// - Doubled clock mode follows the clock doubling fuse.
// - User row writes are blocked unless the user row fuse is enabled.
// - Clock source follows the select fuse: external or crystal.
// - Parallel busy goes low within 256 us of strobe returning high.
// - Serial link is SPI mode 1, sampled on falling clock edge.
// - Serial page write ends within 4.5 ms, chip erase within 9 ms.
// - Serial page data starts at byte zero after command and page bytes.
`include "nps_regs.svh"
`default_nettype none
module nps_sequencer
  import nps_pkg::*;
#(
  parameter int FIXED_CYC    = `NPS_FIXED_CYC,
  parameter int PAGE_CYC     = `NPS_PAGE_CYC,
  parameter int LOAD_GAP_CYC = `NPS_LOAD_GAP_CYC,
  parameter int CODE_PAGE    = `NPS_CODE_PAGE_BYTES,
  parameter int DATA_PAGE    = `NPS_DATA_PAGE_BYTES
) (
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  input  wire logic        par_en_i,
  input  wire logic        prog_strobe_n_i,
  input  wire logic [2:0]  par_mode_i,
  input  wire logic [13:0] par_addr_i,
  input  wire logic [7:0]  par_data_i,
  input  wire logic        ser_en_i,
  input  wire logic        sck_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  output logic             busy_indicator_pin_o,
  output logic             ready_busy_flag_o,
  output logic             nvm_valid_o,
  input  wire logic        nvm_ready_i,
  output logic [2:0]       nvm_op_o,
  output logic [13:0]      nvm_addr_o,
  output logic [7:0]       nvm_data_o,
  output logic             prog_start_o,
  output logic             prog_done_o,
  output logic [2:0]       prog_op_o,
  output logic             page_overflow_o,
  output logic [2:0]       lock_bits_o,
  output logic             serial_prog_enable_fuse_o,
  output logic             doubled_clock_mode_o,
  output logic             user_row_write_fuse_o,
  output logic             clock_source_select_fuse_o
);
  localparam int SW = 3 + 14 + 8;

  if (FIXED_CYC < 1 || PAGE_CYC < 1 || LOAD_GAP_CYC < 1 || FIXED_CYC >= 2**`NPS_TMR_W
      || PAGE_CYC >= 2**`NPS_TMR_W || FIXED_CYC > `NPS_ERASE_MAX_CYC || LOAD_GAP_CYC >= `NPS_BUSY_MAX_CYC
      || CODE_PAGE != 64 || DATA_PAGE != 32) begin : g_bad
    $error("nps_sequencer: unsupported timing or page parameters");
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [29:0] s1_q;
  logic [29:0] s2_q;
  logic        strobe_prev_q;
  logic        sck_prev_q;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q          <= 30'h10000000;
      s2_q          <= 30'h10000000;
      strobe_prev_q <= 1'b1;
      sck_prev_q    <= 1'b0;
    end else begin
      s1_q          <= {par_en_i, prog_strobe_n_i, par_mode_i, par_addr_i, par_data_i, ser_en_i, sck_i, mosi_i};
      s2_q          <= s1_q;
      strobe_prev_q <= s2_q[28];
      sck_prev_q    <= s2_q[1];
    end
  end

  logic        par_en_s;
  logic [2:0]  mode_s;
  logic [13:0] addr_s;
  logic [7:0]  data_s;
  logic        ser_en_s;
  logic        mosi_s;
  logic        strobe_rise;
  logic        sck_fall;
  logic        sck_rise;
  logic [3:0]  fuse_q;
  logic        ser_ok;

  assign par_en_s    = s2_q[29];
  assign mode_s      = s2_q[27:25];
  assign addr_s      = s2_q[24:11];
  assign data_s      = s2_q[10:3];
  assign ser_en_s    = s2_q[2] ;
  assign mosi_s      = s2_q[0];
  assign strobe_rise = par_en_s & s2_q[28] & ~strobe_prev_q;
  assign sck_fall    = ~s2_q[1] & sck_prev_q;
  assign sck_rise    = s2_q[1] & ~sck_prev_q;
  assign ser_ok      = ser_en_s & ~par_en_s & ~fuse_q[`NPS_FUSE_SER_EN_BIT];

  // ****************************************************************
  // Serial shifter
  // ****************************************************************
  logic [6:0] shift_q;
  logic [2:0] bit_q;
  logic       ser_byte_v;
  logic [7:0] ser_byte;
  nps_state_t state_q;

  assign ser_byte_v = ser_ok & sck_fall & (bit_q == 3'h7);
  assign ser_byte   = {shift_q, mosi_s};

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_q <= 7'h00;
      bit_q   <= 3'h0;
      miso_o  <= 1'b0;
    end else if (!ser_ok) begin
      bit_q   <= 3'h0;
    end else begin
      if (sck_fall) begin
        shift_q <= ser_byte[6:0];
        bit_q   <= bit_q + 3'h1;
      end
      if (sck_rise) begin
        miso_o <= (state_q == ST_IDLE);
      end
    end
  end

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic [6:0]  ser_idx_q;
  nps_op_t     ser_op_q;
  logic [7:0]  ser_page_q;
  nps_op_t     cur_op_q;
  logic [6:0]  load_cnt_q;
  logic        load_ser_q;
  logic        hold_v_q;
  logic [SW-1:0] hold_q;
  logic        buf_ready;
  logic        buf_empty;

  nps_op_t     new_op;
  logic        start_fixed;
  logic [7:0]  fixed_data;
  logic        open_page;
  logic        take_byte;
  logic [13:0] byte_addr;
  logic [7:0]  byte_data;
  logic        ser_last;
  logic [6:0]  limit;
  logic [6:0]  off;

  function automatic logic is_page(nps_op_t op);
    return (op == OP_CODE_PAGE) || (op == OP_DATA_PAGE) || (op == OP_USER_PAGE);
  endfunction : is_page

  always_comb begin
    new_op      = OP_NONE;
    start_fixed = 1'b0;
    fixed_data  = 8'h00;
    open_page   = 1'b0;
    take_byte   = 1'b0;
    byte_addr   = addr_s;
    byte_data   = data_s;
    ser_last    = 1'b0;
    off         = ser_idx_q - 7'h02;
    limit       = (cur_op_q == OP_DATA_PAGE) ? 7'(DATA_PAGE) : 7'(CODE_PAGE);
    if (strobe_rise && !ser_en_s) begin
      new_op = nps_op_t'(mode_s);
      if (state_q == ST_IDLE) begin
        start_fixed = (new_op == OP_ERASE) || (new_op == OP_LOCK) || (new_op == OP_FUSE);
        fixed_data  = data_s;
        open_page   = is_page(new_op);
        take_byte   = open_page;
      end else if (state_q == ST_LOAD && !load_ser_q && new_op == cur_op_q) begin
        take_byte = 1'b1;
      end
    end else if (ser_byte_v && (state_q == ST_IDLE || (state_q == ST_LOAD && load_ser_q))) begin
      if (ser_idx_q == 7'h00) begin
        start_fixed = (nps_op_t'(ser_byte[2:0]) == OP_ERASE);
        new_op      = nps_op_t'(ser_byte[2:0]);
      end else if (ser_idx_q == 7'h01) begin
        new_op      = ser_op_q;
        start_fixed = (ser_op_q == OP_LOCK) || (ser_op_q == OP_FUSE);
        fixed_data  = ser_byte;
        open_page   = is_page(ser_op_q);
      end else begin
        take_byte = 1'b1;
        byte_data = ser_byte;
        ser_last  = (off == limit - 7'h01);
        byte_addr = (cur_op_q == OP_DATA_PAGE) ? {1'b0, ser_page_q, off[4:0]} : {ser_page_q, off[5:0]};
      end
    end
    if (open_page && new_op == OP_USER_PAGE && fuse_q[`NPS_FUSE_USR_ROW_BIT]) begin
      open_page = 1'b0;
      take_byte = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ser_idx_q  <= 7'h00;
      ser_op_q   <= OP_NONE;
      ser_page_q <= 8'h00;
    end else if (!ser_ok || state_q == ST_PROG) begin
      ser_idx_q  <= 7'h00;
    end else if (ser_byte_v) begin
      if (ser_idx_q == 7'h00) begin
        ser_op_q  <= nps_op_t'(ser_byte[2:0]);
        ser_idx_q <= (nps_op_t'(ser_byte[2:0]) == OP_ERASE) ? 7'h00 : 7'h01;
      end else if (ser_idx_q == 7'h01) begin
        ser_page_q <= ser_byte;
        ser_idx_q  <= open_page ? 7'h02 : 7'h00;
      end else begin
        ser_idx_q <= ser_last ? 7'h00 : ser_idx_q + 7'h01;
      end
    end
  end

  // ****************************************************************
  // Page byte path
  // ****************************************************************
  logic push_ok;

  assign push_ok = take_byte && (open_page || load_cnt_q < limit);

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_v_q        <= 1'b0;
      hold_q          <= '0;
      load_cnt_q      <= 7'h00;
      page_overflow_o <= 1'b0;
    end else begin
      if (push_ok) begin
        hold_v_q   <= 1'b1;
        hold_q     <= {(open_page ? new_op : cur_op_q), byte_addr, byte_data};
        load_cnt_q <= load_cnt_q + 7'h01;
      end else if (buf_ready) begin
        hold_v_q <= 1'b0;
      end
      if (open_page) begin
        page_overflow_o <= 1'b0;
        load_cnt_q      <= 7'(push_ok);
      end else if (take_byte && !push_ok) begin
        page_overflow_o <= 1'b1;
      end
    end
  end

  nps_buf #(
    .WIDTH (SW),
    .DEPTH (2)
  ) u_buf (
    .mclk_i      (mclk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (hold_v_q),
    .in_ready_o  (buf_ready),
    .in_data_i   (hold_q),
    .out_valid_o (nvm_valid_o),
    .out_ready_i (nvm_ready_i),
    .out_data_o  ({nvm_op_o, nvm_addr_o, nvm_data_o}),
    .empty_o     (buf_empty)
  );

  // ****************************************************************
  // Sequencer and self-timed cycle
  // ****************************************************************
  logic [`NPS_TMR_W-1:0] tmr_q;
  logic [7:0]            cur_data_q;
  logic [2:0]            lock_q;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q      <= ST_IDLE;
      tmr_q        <= '0;
      cur_op_q     <= OP_NONE;
      cur_data_q   <= 8'h00;
      load_ser_q   <= 1'b0;
      prog_start_o <= 1'b0;
      prog_done_o  <= 1'b0;
      fuse_q       <= `NPS_FUSE_RESET;
      lock_q       <= `NPS_LOCK_RESET;
    end else begin
      prog_start_o <= 1'b0;
      prog_done_o  <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start_fixed) begin
            state_q      <= ST_PROG;
            cur_op_q     <= new_op;
            cur_data_q   <= fixed_data;
            tmr_q        <= `NPS_TMR_W'(FIXED_CYC);
            prog_start_o <= 1'b1;
          end else if (open_page) begin
            state_q    <= ST_LOAD;
            cur_op_q   <= new_op;
            load_ser_q <= ser_byte_v;
            tmr_q      <= `NPS_TMR_W'(LOAD_GAP_CYC);
          end
        end
        ST_LOAD: begin
          if (load_ser_q ? (ser_last || !ser_ok) : take_byte) begin
            state_q <= load_ser_q ? ST_WAIT : ST_LOAD;
            tmr_q   <= `NPS_TMR_W'(LOAD_GAP_CYC);
          end else if (!load_ser_q) begin
            tmr_q <= tmr_q - `NPS_TMR_W'(1);
            if (tmr_q == `NPS_TMR_W'(1)) begin
              state_q <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (!hold_v_q && buf_empty) begin
            state_q      <= ST_PROG;
            tmr_q        <= `NPS_TMR_W'(PAGE_CYC);
            prog_start_o <= 1'b1;
          end
        end
        ST_PROG: begin
          tmr_q <= tmr_q - `NPS_TMR_W'(1);
          if (tmr_q == `NPS_TMR_W'(1)) begin
            state_q     <= ST_IDLE;
            prog_done_o <= 1'b1;
            if (cur_op_q == OP_FUSE) begin
              fuse_q <= cur_data_q[3:0];
            end
            if (cur_op_q == OP_LOCK) begin
              lock_q <= lock_q & cur_data_q[2:0];
            end
            if (cur_op_q == OP_ERASE) begin
              lock_q <= `NPS_LOCK_RESET;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Status and fuse outputs
  // ****************************************************************
  assign busy_indicator_pin_o       = (state_q != ST_PROG);
  assign ready_busy_flag_o          = (state_q != ST_PROG);
  assign prog_op_o                  = cur_op_q;
  assign lock_bits_o                = lock_q;
  assign serial_prog_enable_fuse_o  = ~fuse_q[`NPS_FUSE_SER_EN_BIT];
  assign doubled_clock_mode_o       = ~fuse_q[`NPS_FUSE_X2_BIT];
  assign user_row_write_fuse_o      = ~fuse_q[`NPS_FUSE_USR_ROW_BIT];
  assign clock_source_select_fuse_o = fuse_q[`NPS_FUSE_CLK_SEL_BIT];

endmodule : nps_sequencer
`default_nettype wire

// ---- nps_sequencer_sva.sv ----
/*
  Checker of the sequencer ports: busy timing, cycle lengths, load gap,
  fuse gating and the page byte stream.
  Assumes it is bound to nps_sequencer and sees only that module's ports.
*/
`default_nettype none
module nps_sequencer_sva
  import nps_pkg::*;
#(
  parameter int FIXED_CYC    = 40,
  parameter int PAGE_CYC     = 30,
  parameter int LOAD_GAP_CYC = 400
) (
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  input wire logic        par_en_i,
  input wire logic        ser_en_i,
  input wire logic        prog_strobe_n_i,
  input wire logic [2:0]  par_mode_i,
  input wire logic        busy_indicator_pin_o,
  input wire logic        ready_busy_flag_o,
  input wire logic        nvm_valid_o,
  input wire logic        nvm_ready_i,
  input wire logic [2:0]  nvm_op_o,
  input wire logic [13:0] nvm_addr_o,
  input wire logic [7:0]  nvm_data_o,
  input wire logic        prog_start_o,
  input wire logic        prog_done_o,
  input wire logic [2:0]  prog_op_o,
  input wire logic        serial_prog_enable_fuse_o,
  input wire logic        user_row_write_fuse_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  // ****************************************************************
  // Helper counters
  // ****************************************************************
  logic [19:0] low_q;
  logic [9:0]  since_q;
  logic        str_q;
  logic        is_page;
  assign is_page = (prog_op_o == OP_CODE_PAGE) || (prog_op_o == OP_DATA_PAGE) || (prog_op_o == OP_USER_PAGE);

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) low_q <= '0;
    else low_q <= busy_indicator_pin_o ? '0 : low_q + 20'h1;
  end

  // Cycles since the strobe pin last rose, saturating
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      str_q   <= 1'b1;
      since_q <= '1;
    end else begin
      str_q   <= prog_strobe_n_i;
      since_q <= (prog_strobe_n_i && !str_q) ? '0 : ((since_q == 10'h3FF) ? since_q : since_q + 10'h1);
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  sequence s_par_erase;
    $rose(prog_strobe_n_i) && par_en_i && !ser_en_i && par_mode_i == OP_ERASE && ready_busy_flag_o && !nvm_valid_o;
  endsequence
  sequence s_cycle_start;
    prog_start_o && !busy_indicator_pin_o;
  endsequence

  a_erase_start_latency: assert property (s_par_erase |-> ##[1:8] s_cycle_start)
    else $error("erase did not start in time");
  a_start_busy_fall: assert property (prog_start_o |-> !busy_indicator_pin_o && $past(busy_indicator_pin_o))
    else $error("busy did not fall at cycle start");
  a_done_busy_rise: assert property (prog_done_o |-> busy_indicator_pin_o && !$past(busy_indicator_pin_o))
    else $error("busy did not rise at cycle end");
  a_busy_flag_same: assert property (busy_indicator_pin_o == ready_busy_flag_o)
    else $error("busy pin and ready flag differ");
  a_fixed_cycle_len: assert property (prog_done_o && !is_page |-> low_q == FIXED_CYC)
    else $error("fixed cycle length wrong");
  a_page_cycle_len: assert property (prog_done_o && is_page |-> low_q == PAGE_CYC)
    else $error("page cycle length wrong");
  a_page_load_gap: assert property (prog_start_o && is_page && par_en_i |-> since_q >= LOAD_GAP_CYC)
    else $error("page programming started too early");
  a_serial_fuse_gate: assert property (prog_start_o && !par_en_i |-> serial_prog_enable_fuse_o)
    else $error("serial cycle with serial fuse disabled");
  a_user_row_gate: assert property (nvm_valid_o && nvm_op_o == OP_USER_PAGE |-> user_row_write_fuse_o)
    else $error("user row write with fuse disabled");
  a_stream_word_hold: assert property (nvm_valid_o && !nvm_ready_i |=> nvm_valid_o && $stable(nvm_data_o) && $stable(nvm_addr_o))
    else $error("stream word changed while stalled");
endmodule : nps_sequencer_sva

bind nps_sequencer nps_sequencer_sva #(
  .FIXED_CYC(FIXED_CYC), .PAGE_CYC(PAGE_CYC), .LOAD_GAP_CYC(LOAD_GAP_CYC)
) u_nps_sequencer_sva (.*);
`default_nettype wire

// ---- nps_prog_model.sv ----
/*
  External programmer model: strobed parallel writes and SPI mode 1 bytes.
  Assumes the sequencer clock on mclk_i; tasks are called from the bench.
*/
`default_nettype none
module nps_prog_model (
  input  wire logic  mclk_i,
  output logic       strobe_n_o,
  output logic [2:0] mode_o,
  output logic [13:0] addr_o,
  output logic [7:0] data_o,
  output logic       sck_o,
  output logic       mosi_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    strobe_n_o = 1'b1;
    mode_o     = 3'h0;
    addr_o     = 14'h0000;
    data_o     = 8'h00;
    sck_o      = 1'b0;
    mosi_o     = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : wait_clk

  // One byte per strobe; setup, width and hold of 16 clocks each
  task automatic par_write(input logic [2:0] op, input logic [13:0] a, input logic [7:0] d);
    wait_clk(1);
    mode_o = op;
    addr_o = a;
    data_o = d;
    wait_clk(16);
    strobe_n_o = 1'b0;
    wait_clk(16);
    strobe_n_o = 1'b1;
    wait_clk(16);
    mode_o = ~op;
    addr_o = ~a;
    data_o = ~d;
  endtask : par_write

  // MSB first, data set at rising edge, idle low, each level 62.5 ns
  task automatic ser_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sck_o  = 1'b1;
      mosi_o = b[i];
      #62.5;
      sck_o  = 1'b0;
      #62.5;
    end
    mosi_o = ~b[0];
  endtask : ser_byte
endmodule : nps_prog_model
`default_nettype wire

// ---- tb_nps_sequencer.sv ----
/*
  Self-checking bench of the sequencer: parallel and serial operations.
  Assumes nps_prog_model as programmer and a stalling array sink here.
*/
`default_nettype none
module tb_nps_sequencer;
  import nps_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FIX = 40;
  localparam int PG  = 30;
  localparam int GAP = 400;

  logic mclk_i = 1'b0, nrst_i = 1'b0, par_en_i = 1'b0, ser_en_i = 1'b0, nvm_ready_i = 1'b1, stall = 1'b0;
  logic strobe_n, sck, mosi, miso_o, busy_o, ready_o, nvm_valid_o, start_o, done_o, ovf_o;
  logic ser_f, x2_f, usr_f, clk_f;
  logic [2:0] mode, nvm_op_o, prog_op_o, lock_o;
  logic [13:0] addr, nvm_addr_o, fa;
  logic [7:0] data, nvm_data_o;
  int bad_count = 0, compares = 0, nw = 0, cyc = 0, lowc = 0, last_low = 0, lat = 0, last_lat = 0;
  logic sp_q = 1'b1;

  always #4 mclk_i = ~mclk_i;

  nps_sequencer #(.FIXED_CYC(FIX), .PAGE_CYC(PG), .LOAD_GAP_CYC(GAP)) u_nps_sequencer (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .par_en_i(par_en_i), .prog_strobe_n_i(strobe_n), .par_mode_i(mode),
    .par_addr_i(addr), .par_data_i(data), .ser_en_i(ser_en_i), .sck_i(sck), .mosi_i(mosi), .miso_o(miso_o),
    .busy_indicator_pin_o(busy_o), .ready_busy_flag_o(ready_o), .nvm_valid_o(nvm_valid_o),
    .nvm_ready_i(nvm_ready_i), .nvm_op_o(nvm_op_o), .nvm_addr_o(nvm_addr_o), .nvm_data_o(nvm_data_o),
    .prog_start_o(start_o), .prog_done_o(done_o), .prog_op_o(prog_op_o), .page_overflow_o(ovf_o),
    .lock_bits_o(lock_o), .serial_prog_enable_fuse_o(ser_f), .doubled_clock_mode_o(x2_f),
    .user_row_write_fuse_o(usr_f), .clock_source_select_fuse_o(clk_f));
  nps_prog_model u_nps_prog_model (.mclk_i(mclk_i), .strobe_n_o(strobe_n), .mode_o(mode), .addr_o(addr),
    .data_o(data), .sck_o(sck), .mosi_o(mosi));

  // ****************************************************************
  // Sink, busy monitor and timeout
  // ****************************************************************
  always @(posedge mclk_i) begin
    cyc++;
    if (nvm_valid_o === 1'b1 && nvm_ready_i === 1'b1) begin
      if (nw == 0) fa = nvm_addr_o;
      nw++;
    end
    if (strobe_n === 1'b1 && sp_q === 1'b0) lat = 0;
    else lat++;
    sp_q = strobe_n;
    if (busy_o === 1'b0) begin
      if (lowc == 0) last_lat = lat;
      lowc++;
    end else if (lowc > 0) begin
      last_low = lowc;
      lowc = 0;
    end
    if (cyc >= 60000) begin
      bad_count++;
      give_verdict();
    end
    #1 nvm_ready_i = !stall || (cyc[1:0] == 2'h0);
  end

  task automatic chk(input logic [15:0] exp, input logic [15:0] seen, input string what);
    compares++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask : chk

  // Waits for a completed busy period and compares its length
  task automatic run(input int exp, input string what);
    int t;
    t = 0;
    last_low = 0;
    while (last_low == 0 && t < 3000) begin
      @(posedge mclk_i);
      t++;
    end
    #1;
    chk(16'(exp), 16'(last_low), what);
  endtask : run

  task automatic par_page(input logic [2:0] op, input logic [13:0] base, input int n);
    nw = 0;
    for (int i = 0; i < n; i++) u_nps_prog_model.par_write(op, base + 14'(i), 8'hA0 + 8'(i));
  endtask : par_page

  task automatic give_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge mclk_i);
    #1;
    nrst_i = 1'b1;
    par_en_i = 1'b1;
    u_nps_prog_model.wait_clk(4);
    chk(16'h03FC, {6'h00, busy_o, ready_o, lock_o, ser_f, x2_f, usr_f, clk_f, ovf_o}, "reset outputs");
    u_nps_prog_model.par_write(OP_ERASE, 14'h0000, 8'h00);
    run(FIX, "erase busy");
    chk(16'h0001, 16'(last_lat <= 8), "erase latency");
    u_nps_prog_model.par_write(OP_LOCK, 14'h0000, 8'hFA);
    run(FIX, "lock busy");
    chk(16'h0002, 16'(lock_o), "lock bits");
    stall = 1'b1;
    par_page(OP_CODE_PAGE, 14'h0100, 65);
    run(PG, "code page busy");
    stall = 1'b0;
    chk(16'd64, 16'(nw), "code bytes");
    chk(16'h0001, 16'(ovf_o), "code overflow");
    chk(16'h0100, 16'(fa), "code first addr");
    chk(16'h0001, 16'(last_lat >= GAP), "page gap");
    chk(16'h0001, 16'(last_lat < GAP + 300), "page busy latency");
    par_page(OP_DATA_PAGE, 14'h0040, 33);
    run(PG, "data page busy");
    chk(16'd32, 16'(nw), "data bytes");
    chk(16'h0001, 16'(ovf_o), "data overflow");
    par_page(OP_USER_PAGE, 14'h0000, 1);
    run(PG, "user page busy");
    chk(16'd1, 16'(nw), "user bytes");
    u_nps_prog_model.par_write(OP_FUSE, 14'h0000, 8'h0E);
    run(FIX, "fuse busy");
    chk(16'h0009, {12'h000, ser_f, x2_f, usr_f, clk_f}, "fuses");
    par_page(OP_USER_PAGE, 14'h0000, 1);
    run(0, "blocked user page");
    chk(16'd0, 16'(nw), "blocked user bytes");
    par_en_i = 1'b0;
    ser_en_i = 1'b1;
    u_nps_prog_model.wait_clk(4);
    nw = 0;
    u_nps_prog_model.ser_byte({5'h00, OP_DATA_PAGE});
    u_nps_prog_model.ser_byte(8'h03);
    for (int i = 0; i < 32; i++) u_nps_prog_model.ser_byte(8'h50 + 8'(i));
    run(PG, "serial page busy");
    chk(16'd32, 16'(nw), "serial bytes");
    chk(16'h0060, 16'(fa), "serial first addr");
    u_nps_prog_model.ser_byte({5'h00, OP_ERASE});
    run(FIX, "serial erase busy");
    chk(16'h0007, 16'(lock_o), "locks after erase");
    u_nps_prog_model.ser_byte(8'h00);
    chk(16'h0001, 16'(miso_o), "serial ready");
    u_nps_prog_model.ser_byte(8'h00);
    u_nps_prog_model.ser_byte({5'h00, OP_FUSE});
    u_nps_prog_model.ser_byte(8'h01);
    run(FIX, "serial fuse busy");
    chk(16'h0000, 16'(ser_f), "serial fuse");
    u_nps_prog_model.ser_byte({5'h00, OP_ERASE});
    run(0, "serial erase refused");
    give_verdict();
  end
endmodule : tb_nps_sequencer
`default_nettype wire
